// ### dph_top.sv
// Summary of operation
// R1: Peripheral drives low request to ask service.
// R2: Acknowledge held active during channel transfer.
// R3: While master, pin three is channel request.
// R4: Not master, pin three requests external DRAM.
// R5: While master, pin three ack is channel ack.
// R6: Not master, pin three ack marks valid data.
// R7: Read strobe active on any DRAM read.
// R8: Read strobe lets only selected bank drive.
// R9: Write strobe active on any DRAM write.
// R10: Data pin zero is the most significant bit.
// R11: Requests pass two flops before arbitration.
//
// Purpose: DMA request/acknowledge pins and DRAM strobes for own DMA
//          transfers and for an external master's DRAM accesses.
// Assumes: bus_master_i comes from on-chip logic on clk_i.
// Notes:   Channel 0 has highest priority; each transfer is one access.
`timescale 1ns/1ps
module dph_top
    import dph_pkg::*;
#(
    parameter int XFER_LEN = dph_pkg::XFER_CYCLES,
    parameter int ACC_LEN  = dph_pkg::ACCESS_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    // Ownership and transfer set-up from on-chip logic
    input  wire logic                          bus_master_i,
    input  wire logic [dph_pkg::CHAN_NUM-1:0]  chan_write_i,
    input  wire logic [dph_pkg::BANK_W-1:0]    dram_bank_i,
    input  wire logic [dph_pkg::DATA_W-1:0]    xfer_wdata_i,
    output logic      [dph_pkg::DATA_W-1:0]    xfer_rdata_o,
    // Request pins; channel 3 doubles as the external master request
    input  wire logic                          chan0_xfer_req_n_i,
    input  wire logic                          chan1_xfer_req_n_i,
    input  wire logic                          chan2_xfer_req_n_i,
    input  wire logic                          chan3_xfer_req_n_i,
    input  wire logic                          ext_master_write_i,
    // Acknowledge pins; channel 3 doubles as external data valid
    output logic                               chan0_xfer_ack_n_o,
    output logic                               chan1_xfer_ack_n_o,
    output logic                               chan2_xfer_ack_n_o,
    output logic                               chan3_xfer_ack_n_o,
    // DRAM strobes and bank enables
    output logic                               dram_read_strobe_n_o,
    output logic                               dram_write_strobe_n_o,
    output logic      [dph_pkg::BANK_NUM-1:0]  dram_bank_en_o,
    // Data bus pins, index 0 is the most significant bit
    input  wire logic [0:dph_pkg::DATA_W-1]    data_bus_i,
    output logic      [0:dph_pkg::DATA_W-1]    data_bus_o,
    output logic                               data_bus_oe_o
);
    import dph_pkg::*;

    localparam logic [CNT_W-1:0] XFER_LAST = CNT_W'(XFER_LEN - 1);
    localparam logic [CNT_W-1:0] ACC_LAST  = CNT_W'(ACC_LEN - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pin 0 is the word's bit 31. A plain assignment between the [0:31]
    // pins and a [31:0] word maps left to right, so no swap is needed.
    function automatic logic [BANK_NUM-1:0] one_hot(
        input logic [BANK_W-1:0] sel
    );
        logic [BANK_NUM-1:0] r;
        r = '0;
        r[sel] = 1'h1;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    dph_sync_if #(.W(SYNC_W)) sif ();

    assign sif.raw = {data_bus_i, ext_master_write_i, chan3_xfer_req_n_i,
                      chan2_xfer_req_n_i, chan1_xfer_req_n_i,
                      chan0_xfer_req_n_i};

    dph_sync #(
        .W       (SYNC_W),
        .RST_VAL ({{(SYNC_W-CHAN_NUM){1'h0}}, {CHAN_NUM{1'h1}}})
    ) u_sync (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .sif     (sif)
    ); // [R11]

    logic [CHAN_NUM-1:0] req_n_s;
    logic                ext_wr_s;
    logic [DATA_W-1:0]   data_s;
    logic [CHAN_NUM-1:0] chan_req;

    assign req_n_s  = sif.sync[CHAN_NUM-1:0];
    assign ext_wr_s = sif.sync[SYNC_EXT_WR];
    assign data_s   = sif.sync[SYNC_W-1:SYNC_DATA_LO];
    // Channel 3 only counts as a DMA request while we own the bus.
    assign chan_req = ~req_n_s & {bus_master_i, 3'h7}; // [R1] [R3]

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    dph_state_t                  state;
    dph_state_t                  next_state;
    logic [CNT_W-1:0]            cnt;
    logic [CNT_W-1:0]            next_cnt;
    logic [1:0]                  chan;
    logic [1:0]                  next_chan;
    logic                        wr;
    logic                        next_wr;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_chan  = chan;
        next_wr    = wr;
        case (state)
            ST_IDLE: begin
                if (bus_master_i && (|chan_req)) begin
                    next_state = ST_CHAN;
                    next_cnt   = XFER_LAST;
                    next_chan  = chan_req[0] ? 2'h0 :
                                 chan_req[1] ? 2'h1 :
                                 chan_req[2] ? 2'h2 : 2'h3;
                    next_wr    = chan_write_i[next_chan];
                end else if (!bus_master_i && !req_n_s[EXT_CHAN]) begin
                    next_state = ST_EXT_ACC; // [R4]
                    next_cnt   = ACC_LAST;
                    next_wr    = ext_wr_s;
                end
            end
            ST_CHAN: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            ST_EXT_ACC: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_EXT_DATA;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            ST_EXT_DATA: begin
                next_state = ST_EXT_END;
            end
            ST_EXT_END: begin
                // One access per request: wait for the master to let go.
                if (req_n_s[EXT_CHAN] || bus_master_i) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            cnt   <= CNT_ZERO;
            chan  <= 2'h0;
            wr    <= 1'h0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            chan  <= next_chan;
            wr    <= next_wr;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs, registered from the next state
    // ------------------------------------------------------------
    logic in_chan;
    logic dram_busy;

    assign in_chan   = (next_state == ST_CHAN);
    assign dram_busy = in_chan || (next_state == ST_EXT_ACC) ||
                       (next_state == ST_EXT_DATA);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            chan0_xfer_ack_n_o <= PIN_IDLE;
            chan1_xfer_ack_n_o <= PIN_IDLE;
            chan2_xfer_ack_n_o <= PIN_IDLE;
            chan3_xfer_ack_n_o <= PIN_IDLE;
        end else begin
            chan0_xfer_ack_n_o <= ~(in_chan && next_chan == 2'h0); // [R2]
            chan1_xfer_ack_n_o <= ~(in_chan && next_chan == 2'h1); // [R2]
            chan2_xfer_ack_n_o <= ~(in_chan && next_chan == 2'h2); // [R2]
            // Channel ack while master, data valid otherwise.
            chan3_xfer_ack_n_o <= ~((in_chan && next_chan == 2'h3) ||
                                   next_state == ST_EXT_DATA); // [R5] [R6]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            dram_read_strobe_n_o  <= PIN_IDLE;
            dram_write_strobe_n_o <= PIN_IDLE;
            dram_bank_en_o        <= '0;
        end else begin
            dram_read_strobe_n_o  <= ~(dram_busy && !next_wr); // [R7]
            dram_write_strobe_n_o <= ~(dram_busy && next_wr);  // [R9]
            dram_bank_en_o <= dram_busy ? one_hot(dram_bank_i) : '0; // [R8]
        end
    end

    // The external master drives its own write data, so we only drive
    // the bus for our own writes and never while a bank is read.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            data_bus_oe_o <= 1'h0;
            data_bus_o    <= '0;
            xfer_rdata_o  <= '0;
        end else begin
            data_bus_oe_o <= in_chan && next_wr; // [R8]
            data_bus_o    <= xfer_wdata_i; // [R10]
            if (state == ST_CHAN && !wr && cnt == CNT_ZERO) begin
                xfer_rdata_o <= data_s; // [R10]
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    one_ack_only_a: assert property ( // [R2]
        $onehot0(~{chan0_xfer_ack_n_o, chan1_xfer_ack_n_o,
                   chan2_xfer_ack_n_o, chan3_xfer_ack_n_o}))
        else $error("more than one acknowledge active");
    ack_length_a: assert property ( // [R2]
        $fell(chan0_xfer_ack_n_o) |->
            (!chan0_xfer_ack_n_o) [*4] ##1 chan0_xfer_ack_n_o)
        else $error("channel 0 acknowledge length wrong");
    read_no_drive_a: assert property ( // [R8]
        !dram_read_strobe_n_o |-> !data_bus_oe_o)
        else $error("data driven during DRAM read");
    strobe_excl_a: assert property ( // [R7] [R9]
        dram_read_strobe_n_o || dram_write_strobe_n_o)
        else $error("read and write strobes both active");
    bank_gated_a: assert property ( // [R8]
        (dram_read_strobe_n_o && dram_write_strobe_n_o) ==
        (dram_bank_en_o == '0))
        else $error("bank enable outside a strobe");
    ext_valid_a: assert property ( // [R6]
        (state == ST_EXT_ACC && cnt == CNT_ZERO) |=>
            !chan3_xfer_ack_n_o && ((!dram_read_strobe_n_o) != wr))
        else $error("external data valid missing");
    ext_start_a: assert property ( // [R4]
        (state == ST_IDLE && !bus_master_i && !req_n_s[EXT_CHAN]) |=>
            (!dram_read_strobe_n_o || !dram_write_strobe_n_o) ##[2:2]
            !chan3_xfer_ack_n_o)
        else $error("external request not served in time");
    chan3_owner_a: assert property ( // [R3]
        (state == ST_IDLE && !bus_master_i && req_n_s[EXT_CHAN]) |=>
            chan3_xfer_ack_n_o && dram_read_strobe_n_o &&
            dram_write_strobe_n_o)
        else $error("channel 3 served without bus ownership");
    write_strobe_a: assert property ( // [R9]
        (state == ST_IDLE && next_state == ST_CHAN && next_wr) |=>
            !dram_write_strobe_n_o && data_bus_oe_o)
        else $error("write strobe missing on own write");

    chan_read_c:  cover property ($fell(chan0_xfer_ack_n_o) &&
                                  !dram_read_strobe_n_o);
    chan3_dma_c:  cover property ($fell(chan3_xfer_ack_n_o) &&
                                  bus_master_i);
    ext_write_c:  cover property ($fell(chan3_xfer_ack_n_o) &&
                                  !dram_write_strobe_n_o);
    ext_read_c:   cover property ($fell(chan3_xfer_ack_n_o) &&
                                  !dram_read_strobe_n_o);
endmodule

// ### dph_pkg.sv
// Purpose: Shared constants for the DMA handshake and DRAM strobe block.
// Assumes: One 100 MHz system clock; request, acknowledge and strobe pins are active low.
// Notes:   Pin bit 0 of the data bus carries the most significant bit.
package dph_pkg;
    localparam int          CHAN_NUM      = 4;
    localparam int          EXT_CHAN      = 3;
    localparam int          DATA_W        = 32;
    localparam int          BANK_NUM      = 4;
    localparam int          BANK_W        = 2;
    localparam int          CNT_W         = 4;
    localparam int          SYNC_W        = CHAN_NUM + 1 + DATA_W;
    localparam int          SYNC_EXT_WR   = CHAN_NUM;
    localparam int          SYNC_DATA_LO  = CHAN_NUM + 1;
    localparam int          XFER_CYCLES   = 4;
    localparam int          ACCESS_CYCLES = 2;
    localparam logic        PIN_IDLE      = 1'h1;
    localparam logic        PIN_ACTIVE    = 1'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHAN,
        ST_EXT_ACC,
        ST_EXT_DATA,
        ST_EXT_END
    } dph_state_t;
endpackage

// ### dph_sync_if.sv
// Purpose: Carries raw pin levels into the synchroniser and back out.
// Assumes: Used only between the block's own modules.
// Notes:   Raw side is asynchronous; sync side is on clk_i.
`timescale 1ns/1ps
interface dph_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport snk (input raw, output sync);
endinterface

// ### dph_sync.sv
// Purpose: Two-flop synchroniser for every asynchronous pin input.
// Assumes: Synchronous active-low reset.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module dph_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Pins in, synchronised levels out
    dph_sync_if.snk   sif
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
        end else begin
            stage1 <= sif.raw;
            stage2 <= stage1;
        end
    end

    assign sif.sync = stage2;
endmodule

// ### dph_dram_model.sv
// Purpose: DRAM banks behind the block's strobes, used by the bench.
// Assumes: Strobes and bank enables come from dph_top on clk_i.
// Notes:   An undriven bus shows a pattern that flips every cycle.
`timescale 1ns/1ps
module dph_dram_model #(
    parameter logic [31:0] BASE = 32'hC0DE0000
) (
    // Clock
    input  wire logic                         clk_i,
    // Strobes and bank selects from the block
    input  wire logic                         rd_n_i,
    input  wire logic                         wr_n_i,
    input  wire logic [dph_pkg::BANK_NUM-1:0] bank_en_i,
    // Data bus pins as seen by the banks
    input  wire logic [0:dph_pkg::DATA_W-1]   bus_i,
    input  wire logic                         oe_i,
    output logic      [0:dph_pkg::DATA_W-1]   bus_o
);
    import dph_pkg::*;
    logic [DATA_W-1:0] mem [BANK_NUM];
    logic [DATA_W-1:0] junk = 32'h5A5A5A5A;
    int                sel;

    initial begin
        for (int b = 0; b < BANK_NUM; b++) begin
            mem[b] = BASE + 32'(b);
        end
    end

    always_comb begin
        sel = 0;
        for (int b = 0; b < BANK_NUM; b++) begin
            if (bank_en_i[b]) begin
                sel = b;
            end
        end
    end

    // A released bus must not look like stale data, so it keeps moving.
    always @(posedge clk_i) begin
        junk <= ~junk;
        if (!wr_n_i && oe_i) begin
            mem[sel] <= bus_i;
        end
    end

    // Only the enabled bank drives; pin 0 carries the word's top bit.
    assign bus_o = (!rd_n_i && |bank_en_i) ? mem[sel] : junk;
endmodule

// ### dph_top_test.sv
// Purpose: Self-checking bench for the DMA handshake and DRAM strobes.
// Assumes: Inputs change on the falling edge of clk_i.
// Notes:   Requests pass two sync flops, so strobes start late.
`timescale 1ns/1ps
module dph_top_test;
    import dph_pkg::*;
    // Two sync edges, then the decision edge launches the strobe: edge 3.
    localparam int FIRST = 3;
    localparam int XL    = XFER_CYCLES;
    localparam int AL    = ACCESS_CYCLES;
    logic        clk_i  = 1'h0;
    logic        rstn_i = 1'h0;
    logic        bm     = 1'h1;
    logic [3:0]  cw     = 4'h0;
    logic [1:0]  bank   = 2'h0;
    logic [31:0] wd     = 32'h0;
    logic [3:0]  req_n  = 4'hF;
    logic        xw     = 1'h0;
    logic [31:0] rdata;
    logic [3:0]  ack_n, ben, acks, bens;
    logic        rd_n, wr_n, oe;
    logic [0:31] bin, bout, seen;
    int          fail_count = 0;
    int          checked    = 0;
    int          first, nrd, nwr, nack, ack_at, noe;

    always #5 clk_i = ~clk_i;

    dph_top #(.XFER_LEN(XL), .ACC_LEN(AL)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .bus_master_i(bm),
        .chan_write_i(cw), .dram_bank_i(bank), .xfer_wdata_i(wd),
        .xfer_rdata_o(rdata),
        .chan0_xfer_req_n_i(req_n[0]), .chan1_xfer_req_n_i(req_n[1]),
        .chan2_xfer_req_n_i(req_n[2]), .chan3_xfer_req_n_i(req_n[3]),
        .ext_master_write_i(xw),
        .chan0_xfer_ack_n_o(ack_n[0]), .chan1_xfer_ack_n_o(ack_n[1]),
        .chan2_xfer_ack_n_o(ack_n[2]), .chan3_xfer_ack_n_o(ack_n[3]),
        .dram_read_strobe_n_o(rd_n), .dram_write_strobe_n_o(wr_n),
        .dram_bank_en_o(ben), .data_bus_i(bin), .data_bus_o(bout),
        .data_bus_oe_o(oe)
    );

    dph_dram_model u_mem (
        .clk_i(clk_i), .rd_n_i(rd_n), .wr_n_i(wr_n), .bank_en_i(ben),
        .bus_i(bout), .oe_i(oe), .bus_o(bin)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d failures=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watches 20 falling edges; rel drops the requests at the first strobe.
    task automatic observe(input bit rel);
        first = 0; nrd = 0; nwr = 0; nack = 0; ack_at = 0; noe = 0;
        acks = 4'h0; bens = 4'h0; seen = 32'h0;
        for (int i = 1; i <= 20; i++) begin
            @(negedge clk_i);
            if (first == 0 && (rd_n === 1'h0 || wr_n === 1'h0)) begin
                first = i;
                if (rel) begin
                    req_n = 4'hF;
                end
            end
            nrd += (rd_n === 1'h0);
            nwr += (wr_n === 1'h0);
            if (ack_n !== 4'hF) begin
                nack++;
                ack_at = i;
            end
            acks |= ~ack_n;
            bens |= ben;
            if (oe === 1'h1) begin
                noe++;
                seen = bout;
            end
        end
        if (first == 0) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, FIRST);
            finish_test();
        end
    endtask

    task automatic t_reset_idle();
        @(negedge clk_i);
        check({ack_n, rd_n, wr_n, ben, oe}, 32'h7E0);
        $display("reset idle done");
    endtask

    task automatic t_own_read(input int ch);
        @(negedge clk_i);
        bm = 1'h1;
        cw = 4'h0;
        bank = 2'(ch);
        req_n[ch] = 1'h0;
        observe(1'b1);
        check(first, FIRST);
        check(nrd, XL);
        check(acks, 4'h1 << ch);
        check(nack, XL);
        check(bens, 4'h1 << ch);
        check(nwr + noe, 0);
        check(rdata, 32'hC0DE0000 + 32'(ch));
        $display("own read ch%0d done", ch);
    endtask

    task automatic t_own_write();
        @(negedge clk_i);
        cw = 4'h2;
        bank = 2'h2;
        wd = 32'h80000002;
        req_n[1] = 1'h0;
        observe(1'b1);
        check(nwr, XL);
        check(noe, XL);
        check(nrd, 0);
        check(acks, 4'h2);
        check({seen[0], seen[30], seen[31]}, 32'h6);
        check(u_mem.mem[2], wd);
        $display("own write done");
    endtask

    task automatic t_ext(input logic wr);
        @(negedge clk_i);
        bm = 1'h0;
        xw = wr;
        bank = 2'h3;
        req_n[3] = 1'h0;
        // The request stays low, so a second access must not start.
        observe(1'b0);
        req_n[3] = 1'h1;
        check(first, FIRST);
        check(wr ? nwr : nrd, AL + 1);
        check(wr ? nrd : nwr, 0);
        check(nack, 1);
        check(acks, 4'h8);
        check(ack_at, FIRST + AL);
        check(noe, 0);
        check(bens, 4'h8);
        repeat (4) @(negedge clk_i);
        $display("external access wr=%0d done", wr);
    endtask

    initial begin
        repeat (4) @(negedge clk_i);
        rstn_i = 1'h1;
        t_reset_idle();
        for (int c = 0; c < CHAN_NUM; c++) begin
            t_own_read(c);
        end
        t_own_write();
        t_ext(1'h0);
        t_ext(1'h1);
        finish_test();
    end
endmodule
